// [rtl/fmx_defines.svh]
// front end control constants: register offsets, field positions, power-up values, codes
// assumes a byte-addressed register bus with one 32-bit word per register
`ifndef FMX_DEFINES_SVH
`define FMX_DEFINES_SVH

// ==========================================
// register byte offsets
`define FMX_OFF_CHAN_SEL 8'h00
`define FMX_OFF_ATTEN 8'h04
`define FMX_OFF_COLD_JUNC 8'h08
`define FMX_OFF_EXCITE 8'h0C
`define FMX_OFF_GP_OUT 8'h10
`define FMX_OFF_GP_IN 8'h14

// ==========================================
// field widths and positions
`define FMX_CHAN_W 3
`define FMX_NUM_INPUTS 4
`define FMX_NUM_EXCITE 4
`define FMX_EXCITE_MODE_W 2
`define FMX_GP_W 4
`define FMX_COLD_JUNC_EN_BIT 0
// outputs below this index may use the high-level excitation
`define FMX_HIGH_LEVEL_OUTPUTS 2

// ==========================================
// power-up values (not touched by rst)
`define FMX_PU_CHAN_SEL 3'h0
`define FMX_PU_ATTEN 4'h0
`define FMX_PU_COLD_JUNC 1'h0
`define FMX_PU_EXCITE 8'h00
`define FMX_PU_GP_OUT 4'h0

// ==========================================
// channel select codes
`define FMX_CH_GND_SENSE 3'h4
`define FMX_CH_DIE_TEMP 3'h5
`define FMX_CH_COLD_JUNC 3'h6
`define FMX_CH_VREF 3'h7

// ==========================================
// excitation mode codes
`define FMX_EXC_OFF 2'h0
`define FMX_EXC_POS_DETECT 2'h1
`define FMX_EXC_NEG_DETECT 2'h2
`define FMX_EXC_HIGH_LEVEL 2'h3

// ==========================================
// bus responses
`define FMX_RESP_OKAY 2'h0
`define FMX_RESP_SLVERR 2'h2

`endif

// [rtl/fmx_pkg.sv]
// types shared by the front end control block
// assumes fmx_defines.svh sits on the include path
`include "fmx_defines.svh"

package fmx_pkg;
  typedef logic [`FMX_EXCITE_MODE_W-1:0] fmx_excite_mode_t;
  typedef logic [`FMX_CHAN_W-1:0] fmx_chan_t;
  typedef logic [1:0] fmx_resp_t;
endpackage

// [rtl/fmx_axil_slave.sv]
// axi4-lite slave front: turns bus transfers into one-cycle register strobes
// assumes a register file that decodes wr_addr/rd_addr combinationally
`timescale 1ns/100ps
`default_nettype none
`include "fmx_defines.svh"

module fmx_axil_slave
  import fmx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  fmx_resp_t bresp_q;
  logic rvalid_q;
  fmx_resp_t rresp_q;
  logic [31:0] rdata_q;
  wire aw_take;
  wire w_take;
  wire ar_take;

  // ==========================================
  // write path: address and data may come in either order
  // no new address or data is taken until the response has gone
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_en = aw_have_q && w_have_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `FMX_RESP_OKAY;
    end else begin
      if (aw_take) aw_have_q <= 1'b1;
      if (w_take) w_have_q <= 1'b1;
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `FMX_RESP_OKAY : `FMX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata;
      if (w_take) wstrb_q <= s_axi_wstrb;
    end
  end

  // ==========================================
  // read path: data is sampled at the address handshake
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= `FMX_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? `FMX_RESP_OKAY : `FMX_RESP_SLVERR;
      rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// [rtl/fmx_frontend_ctrl.sv]
// front end switch control: input multiplexer, attenuators, cold junction
// excitation, four excitation sources, general purpose i/o, clock copy
// assumes one 50 mhz clock, synchronous active-high rst, axi4-lite master
//
// Contract
// - three-bit code selects one of eight inputs
// - per-input setting switches in the 4:1 attenuator
// - enable connects cold junction excitation resistor
// - two-bit code: off, source, sink, high-level
// - separate writable mode code per excitation output
// - high-level mode only on outputs zero, one
// - four host-written outputs, four host-read inputs
// - clock output carries continuous copy of clock
// - configuration survives rst; only writes change it
`timescale 1ns/100ps
`default_nettype none
`include "fmx_defines.svh"

module fmx_frontend_ctrl
  import fmx_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NUM_INPUTS = `FMX_NUM_INPUTS,
  parameter int NUM_EXCITE = `FMX_NUM_EXCITE,
  parameter int GP_W = `FMX_GP_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic chan_sel_bit2,
  output logic chan_sel_bit1,
  output logic chan_sel_bit0,
  output logic [NUM_INPUTS-1:0] analog_in_sel,
  output logic gnd_sense_sel,
  output logic die_temp_sensor_sel,
  output logic cold_junction_in_sel,
  output logic vref_sel,
  output logic [NUM_INPUTS-1:0] attenuator_switch,
  output logic cold_junction_excite_en,
  output logic [NUM_EXCITE-1:0] excite_source_pos,
  output logic [NUM_EXCITE-1:0] excite_sink_neg,
  output logic [NUM_EXCITE-1:0] excite_high_level,
  output logic [GP_W-1:0] gp_outputs,
  input wire logic [GP_W-1:0] gp_inputs,
  output logic clock_buffer_out
);
  localparam int EXC_BITS = NUM_EXCITE * `FMX_EXCITE_MODE_W;

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;

  // ==========================================
  // bus front
  fmx_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clock(clock),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ==========================================
  // write decode; all fields live in byte lane 0
  wire [ADDR_W-1:0] wa = {wr_addr[ADDR_W-1:2], 2'b00};
  wire hit_w_chan = (wa == ADDR_W'(`FMX_OFF_CHAN_SEL));
  wire hit_w_atten = (wa == ADDR_W'(`FMX_OFF_ATTEN));
  wire hit_w_cold = (wa == ADDR_W'(`FMX_OFF_COLD_JUNC));
  wire hit_w_excite = (wa == ADDR_W'(`FMX_OFF_EXCITE));
  wire hit_w_gpo = (wa == ADDR_W'(`FMX_OFF_GP_OUT));
  wire hit_w_gpi = (wa == ADDR_W'(`FMX_OFF_GP_IN));
  // the input register is read-only; a write there is accepted and dropped
  assign wr_ok = hit_w_chan | hit_w_atten | hit_w_cold | hit_w_excite | hit_w_gpo | hit_w_gpi;
  wire lane0 = wr_en && wr_strb[0];

  // ==========================================
  // configuration store
  // no rst branch on purpose: a logic reset must not disturb the analog
  // setup; the declared values only define the state at power-up
  fmx_chan_t chan_sel_q = `FMX_PU_CHAN_SEL;
  logic [NUM_INPUTS-1:0] atten_q = NUM_INPUTS'(`FMX_PU_ATTEN);
  logic cold_en_q = `FMX_PU_COLD_JUNC;
  logic [EXC_BITS-1:0] excite_q = EXC_BITS'(`FMX_PU_EXCITE);
  logic [GP_W-1:0] gpo_q = GP_W'(`FMX_PU_GP_OUT);
  logic [EXC_BITS-1:0] excite_d;

  always_ff @(posedge clock) begin
    if (lane0 && hit_w_chan) chan_sel_q <= wr_data[`FMX_CHAN_W-1:0];
    if (lane0 && hit_w_atten) atten_q <= wr_data[NUM_INPUTS-1:0];
    if (lane0 && hit_w_cold) cold_en_q <= wr_data[`FMX_COLD_JUNC_EN_BIT];
    if (lane0 && hit_w_excite) excite_q <= excite_d;
    if (lane0 && hit_w_gpo) gpo_q <= wr_data[GP_W-1:0];
  end

  // ==========================================
  // excitation sources, one slice per output
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXCITE; gi++) begin : g_excite
      localparam int LO = gi * `FMX_EXCITE_MODE_W;
      wire fmx_excite_mode_t req = wr_data[LO +: `FMX_EXCITE_MODE_W];
      wire fmx_excite_mode_t mode = excite_q[LO +: `FMX_EXCITE_MODE_W];
      // outputs without the high-level source store off instead of it
      if (gi < `FMX_HIGH_LEVEL_OUTPUTS) begin : g_full
        assign excite_d[LO +: `FMX_EXCITE_MODE_W] = req;
      end else begin : g_detect_only
        assign excite_d[LO +: `FMX_EXCITE_MODE_W] =
          (req == `FMX_EXC_HIGH_LEVEL) ? `FMX_EXC_OFF : req;
      end
      assign excite_source_pos[gi] = (mode == `FMX_EXC_POS_DETECT);
      assign excite_sink_neg[gi] = (mode == `FMX_EXC_NEG_DETECT);
      assign excite_high_level[gi] = (mode == `FMX_EXC_HIGH_LEVEL);
    end
  endgenerate

  // ==========================================
  // multiplexer and switch decode straight from the stored fields
  assign chan_sel_bit2 = chan_sel_q[2];
  assign chan_sel_bit1 = chan_sel_q[1];
  assign chan_sel_bit0 = chan_sel_q[0];
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_inputs
      assign analog_in_sel[gi] = (chan_sel_q == `FMX_CHAN_W'(gi));
    end
  endgenerate
  assign gnd_sense_sel = (chan_sel_q == `FMX_CH_GND_SENSE);
  assign die_temp_sensor_sel = (chan_sel_q == `FMX_CH_DIE_TEMP);
  assign cold_junction_in_sel = (chan_sel_q == `FMX_CH_COLD_JUNC);
  assign vref_sel = (chan_sel_q == `FMX_CH_VREF);
  assign attenuator_switch = atten_q;
  assign cold_junction_excite_en = cold_en_q;
  assign gp_outputs = gpo_q;

  // ==========================================
  // general purpose inputs: three-stage synchroniser, the stable value
  // updates only when the second and third stages agree
  logic [GP_W-1:0] gpi_s1_q;
  logic [GP_W-1:0] gpi_s2_q;
  logic [GP_W-1:0] gpi_s3_q;
  logic [GP_W-1:0] gpi_q;
  wire [GP_W-1:0] gpi_agree = ~(gpi_s2_q ^ gpi_s3_q);
  wire [GP_W-1:0] gpi_d = (gpi_agree & gpi_s3_q) | (~gpi_agree & gpi_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      gpi_s1_q <= '0;
      gpi_s2_q <= '0;
      gpi_s3_q <= '0;
      gpi_q <= '0;
    end else begin
      gpi_s1_q <= gp_inputs;
      gpi_s2_q <= gpi_s1_q;
      gpi_s3_q <= gpi_s2_q;
      gpi_q <= gpi_d;
    end
  end

  // ==========================================
  // read mux
  wire [ADDR_W-1:0] ra = {rd_addr[ADDR_W-1:2], 2'b00};
  wire hit_r_chan = (ra == ADDR_W'(`FMX_OFF_CHAN_SEL));
  wire hit_r_atten = (ra == ADDR_W'(`FMX_OFF_ATTEN));
  wire hit_r_cold = (ra == ADDR_W'(`FMX_OFF_COLD_JUNC));
  wire hit_r_excite = (ra == ADDR_W'(`FMX_OFF_EXCITE));
  wire hit_r_gpo = (ra == ADDR_W'(`FMX_OFF_GP_OUT));
  wire hit_r_gpi = (ra == ADDR_W'(`FMX_OFF_GP_IN));
  assign rd_ok = hit_r_chan | hit_r_atten | hit_r_cold | hit_r_excite | hit_r_gpo | hit_r_gpi;
  assign rd_data =
    ({32{hit_r_chan}} & 32'(chan_sel_q)) |
    ({32{hit_r_atten}} & 32'(atten_q)) |
    ({32{hit_r_cold}} & 32'(cold_en_q)) |
    ({32{hit_r_excite}} & 32'(excite_q)) |
    ({32{hit_r_gpo}} & 32'(gpo_q)) |
    ({32{hit_r_gpi}} & 32'(gpi_q));

  // ==========================================
  // clock copy: a straight buffer so the host sees the full rate; it is
  // not retimed, so edge alignment to internal logic is only a wire delay
  assign clock_buffer_out = clock;
endmodule

`default_nettype wire

// [testbench/fmx_pin_model.sv]
// model of the external logic on the general purpose input pins
// assumes the bench sets the wanted pin levels
`timescale 1ns/100ps
`default_nettype none
module fmx_pin_model (
  input wire logic [3:0] level,
  output logic [3:0] gp_inputs
);
  // external cmos logic always drives a solid level
  assign gp_inputs = level;
endmodule
`default_nettype wire

// [testbench/fmx_frontend_ctrl_properties.sv]
// checker for the front end switch control block
// assumes binding to fmx_frontend_ctrl with its default widths
`timescale 1ns/100ps
`default_nettype none
module fmx_ctrl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic chan_sel_bit2,
  input wire logic chan_sel_bit1,
  input wire logic chan_sel_bit0,
  input wire logic [3:0] analog_in_sel,
  input wire logic gnd_sense_sel,
  input wire logic die_temp_sensor_sel,
  input wire logic cold_junction_in_sel,
  input wire logic vref_sel,
  input wire logic [3:0] attenuator_switch,
  input wire logic cold_junction_excite_en,
  input wire logic [3:0] excite_source_pos,
  input wire logic [3:0] excite_sink_neg,
  input wire logic [3:0] excite_high_level,
  input wire logic [3:0] gp_outputs,
  input wire logic clock_buffer_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // decode and hold
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_mux_onehot: assert property ({vref_sel, cold_junction_in_sel, die_temp_sensor_sel,
    gnd_sense_sel, analog_in_sel} == 8'h01 << {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0})
    else $error("selected input does not match code");
  chk_excite_excl: assert property (((excite_source_pos & excite_sink_neg) |
    (excite_source_pos & excite_high_level) | (excite_sink_neg & excite_high_level)) == 4'h0)
    else $error("two excitation modes on one output");
  chk_high_only01: assert property (excite_high_level[3:2] == 2'h0)
    else $error("high level excitation on output two or three");
  // sampled just before the falling edge the copy must be high
  chk_clock_copy: assert property (@(negedge clock) clock_buffer_out)
    else $error("clock copy not following clock");
  // and just before the rising edge it must be low, so a stuck copy is caught
  chk_clock_low: assert property (@(posedge clock) !clock_buffer_out)
    else $error("clock copy not low before rising edge");
  chk_cfg_hold: assert property (!$rose(s_axi_bvalid) |-> $stable({chan_sel_bit2,
    chan_sel_bit1, chan_sel_bit0, attenuator_switch, cold_junction_excite_en,
    excite_source_pos, excite_sink_neg, excite_high_level, gp_outputs}))
    else $error("configuration changed without a write");
  // strobe one cycle after the take, response visible the cycle after that
  chk_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_rd_single: assert property (!(s_axi_rvalid && s_axi_arready))
    else $error("read accepted while answer pending");
endmodule
bind fmx_frontend_ctrl fmx_ctrl_chk u_chk (.*);
`default_nettype wire

// [testbench/fmx_frontend_ctrl_tb.sv]
// self-checking bench for the front end switch control block
// assumes the bench is the only bus master; gp pins come from the pin model
`timescale 1ns/100ps
`default_nettype none
module fmx_frontend_ctrl_tb;
  import fmx_pkg::*;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, analog_in_sel, attenuator_switch, gp_outputs, gp_inputs;
  logic [3:0] excite_source_pos, excite_sink_neg, excite_high_level, pin_level = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_rvalid, chan_sel_bit2, chan_sel_bit1, chan_sel_bit0, gnd_sense_sel;
  logic die_temp_sensor_sel, cold_junction_in_sel, vref_sel, cold_junction_excite_en;
  logic clock_buffer_out;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  fmx_frontend_ctrl uut (.*);
  fmx_pin_model u_pins (.level(pin_level), .gp_inputs(gp_inputs));
  initial begin
    forever #10 clock = ~clock;
  end
  // ==========================================
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is sampled before the edge so the decision matches the slave's
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_t, w_t, b_t;
    logic [1:0] got;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      got = s_axi_bresp;
      @(posedge clock);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
    s_axi_bready <= 1'b0;
    cmp(32'(got), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ar_t, v_t;
    logic [31:0] d;
    logic [1:0] got;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar_t = s_axi_arvalid && s_axi_arready;
      v_t = s_axi_rvalid;
      d = s_axi_rdata;
      got = s_axi_rresp;
      @(posedge clock);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!v_t);
    s_axi_rready <= 1'b0;
    cmp(d, e);
    cmp(32'(got), 32'(r));
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================
  // tests
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cmp(32'(analog_in_sel), 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'(c), 2'h0);
      cmp(32'({vref_sel, cold_junction_in_sel, die_temp_sensor_sel, gnd_sense_sel,
        analog_in_sel}), 32'h1 << c);
      cmp(32'({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0}), 32'(c));
      rd(8'h00, 32'(c), 2'h0);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, 32'h1 << i, 2'h0);
      cmp(32'(attenuator_switch), (32'h1 << i) & 32'hf);
      wr(8'h08, 32'(i[0]), 2'h0);
      cmp(32'(cold_junction_excite_en), 32'(i[0]));
    end
    $display("mux, attenuator and cold junction tests done");
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 4; m++) begin
        wr(8'h0C, 32'(m) << (2 * k), 2'h0);
        cmp(32'({excite_high_level, excite_sink_neg, excite_source_pos}),
          (32'(m == 3 && k < 2) << (8 + k)) | (32'(m == 2) << (4 + k)) | (32'(m == 1) << k));
        rd(8'h0C, (m == 3 && k > 1) ? 32'h0 : 32'(m) << (2 * k), 2'h0);
      end
    end
    wr(8'h0C, 32'h0000_00E4, 2'h0);
    cmp(32'({excite_high_level, excite_sink_neg, excite_source_pos}), 32'h0000_0042);
    rd(8'h0C, 32'h0000_0024, 2'h0);
    $display("excitation tests done");
    wr(8'h10, 32'h9, 2'h0);
    cmp(32'(gp_outputs), 32'h9);
    pin_level <= 4'h6;
    repeat (6) @(posedge clock);
    rd(8'h14, 32'h6, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    rd(8'h14, 32'h6, 2'h0);
    wr(8'h18, 32'hff, 2'h2);
    rd(8'h18, 32'h0, 2'h2);
    $display("gp and unmapped tests done");
    wr(8'h04, 32'h5, 2'h0);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cmp(32'({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0, attenuator_switch}), 32'h75);
    cmp(32'({excite_high_level, excite_sink_neg, excite_source_pos, gp_outputs}), 32'h429);
    rd(8'h0C, 32'h0000_0024, 2'h0);
    s_axi_wstrb <= 4'he;
    wr(8'h04, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    cmp(32'(attenuator_switch), 32'h5);
    @(negedge clock);
    #1 cmp(32'(clock_buffer_out), 32'h0);
    @(posedge clock);
    #1 cmp(32'(clock_buffer_out), 32'h1);
    $display("reset hold and clock copy tests done");
    report_and_stop();
  end
endmodule
`default_nettype wire
